//--- jtg_tap.sv
`timescale 1ns/10ps
`default_nettype none
`include "jtg_regs.svh"

module jtg_tap
    import jtg_pkg::*;
#(
    parameter int          NUM_PINS    = 8,
    parameter logic [3:0]  ID_VERSION  = 4'h0,     // Arbitrary value
    parameter logic [15:0] ID_PART     = 16'h0001, // Arbitrary value
    parameter logic [10:0] ID_MAKER    = 11'h001,  // Arbitrary value
    parameter logic [15:0] SILICON_REV = 16'h0001  // Arbitrary value
) (
    // Clock and reset
    input  wire logic                i_clk,
    input  wire logic                i_sys_rst,
    // Test link pins
    input  wire logic                i_tck,
    input  wire logic                i_tms,
    input  wire logic                i_tdi,
    input  wire logic                i_trst_n,
    output logic                     o_tdo,
    output logic                     o_tdo_oe_n,
    // Chip-level port behind the top port
    output logic                     o_chip_tck,
    output logic                     o_chip_tms,
    output logic                     o_chip_tdi,
    input  wire logic                i_chip_tdo,
    // Boundary scan cells
    input  wire logic [NUM_PINS-1:0] i_pin_in,
    output logic      [NUM_PINS-1:0] o_pin_out,
    output logic                     o_pin_extest,
    // Security word from one-time memory
    input  wire logic [31:0]         i_otp_security,
    // Global reset and boot
    input  wire logic                i_chip_rst_n,
    input  wire logic                i_pll_lock,
    input  wire logic [1:0]          i_boot_cfg,
    output logic                     o_core_rst_n,
    output logic                     o_boot_start,
    output logic [1:0]               o_boot_mode,
    output logic                     o_init_overrun
);

    localparam logic [`JTG_INIT_CNT_W-1:0] INIT_CYCLES =
        `JTG_INIT_CNT_W'(`JTG_INIT_CYCLES);

    jtg_tap_state_type     state, next_state;
    jtg_boot_state_type    boot_state;
    logic [NUM_PINS+7:0]   pins_s;
    logic                  tck_s, tms_s, tdi_s, trst_s, ctdo_s, lock_s;
    logic [1:0]            cfg_s;
    logic [NUM_PINS-1:0]   pin_s, bsr_sh;
    logic                  tck_q, tck_rise, tck_fall, tap_rst, byp;
    logic [`JTG_IR_W-1:0]  ir_sh, ir;
    logic [`JTG_DR_W-1:0]  dr_sh, id_word, user_word;
    logic [1:0]            crst_sync;
    logic [`JTG_INIT_CNT_W-1:0] init_cnt;

    // Every pin from outside but the system and chip resets and the security word passes two flops before any logic reads it
    jtg_sync #(
        .WIDTH (NUM_PINS + 8)
    ) u_pin_sync (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_async   ({i_tck, i_tms, i_tdi, i_trst_n, i_chip_tdo,
                     i_pll_lock, i_boot_cfg, i_pin_in}),
        .o_sync    (pins_s)
    );
    assign {tck_s, tms_s, tdi_s, trst_s, ctdo_s, lock_s, cfg_s, pin_s} =
        pins_s;

    // Edge detection of the test clock, from the second stage only;
    // held at the idle low level in reset so no false edge follows it
    always_ff @(posedge i_clk) begin
        tck_q <= tck_s & ~i_sys_rst;
    end
    assign tck_rise = tck_s & ~tck_q;
    assign tck_fall = ~tck_s & tck_q;

    // Tied-low test reset or a locked-out part hold all test port logic in reset, not the boot sequencer
    assign tap_rst = i_sys_rst | ~trst_s
                   | i_otp_security[`JTG_SEC_DIS_BIT];

    // Fixed words presented on capture
    assign id_word = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
    assign user_word = {
        i_otp_security[`JTG_SEC_UID_MSB:`JTG_SEC_UID_LSB],
        6'h00,
        SILICON_REV};

    // Controller next state from the sampled mode select
    always_comb begin
        next_state = state;
        unique case (state)
            JTG_RESET:      next_state = tms_s ? JTG_RESET : JTG_IDLE;
            JTG_IDLE:       next_state = tms_s ? JTG_SEL_DR : JTG_IDLE;
            JTG_SEL_DR:     next_state = tms_s ? JTG_SEL_IR : JTG_CAPTURE_DR;
            JTG_CAPTURE_DR: next_state = tms_s ? JTG_EXIT1_DR : JTG_SHIFT_DR;
            JTG_SHIFT_DR:   next_state = tms_s ? JTG_EXIT1_DR : JTG_SHIFT_DR;
            JTG_EXIT1_DR:   next_state = tms_s ? JTG_UPDATE_DR : JTG_PAUSE_DR;
            JTG_PAUSE_DR:   next_state = tms_s ? JTG_EXIT2_DR : JTG_PAUSE_DR;
            JTG_EXIT2_DR:   next_state = tms_s ? JTG_UPDATE_DR : JTG_SHIFT_DR;
            JTG_UPDATE_DR:  next_state = tms_s ? JTG_SEL_DR : JTG_IDLE;
            JTG_SEL_IR:     next_state = tms_s ? JTG_RESET : JTG_CAPTURE_IR;
            JTG_CAPTURE_IR: next_state = tms_s ? JTG_EXIT1_IR : JTG_SHIFT_IR;
            JTG_SHIFT_IR:   next_state = tms_s ? JTG_EXIT1_IR : JTG_SHIFT_IR;
            JTG_EXIT1_IR:   next_state = tms_s ? JTG_UPDATE_IR : JTG_PAUSE_IR;
            JTG_PAUSE_IR:   next_state = tms_s ? JTG_EXIT2_IR : JTG_PAUSE_IR;
            JTG_EXIT2_IR:   next_state = tms_s ? JTG_UPDATE_IR : JTG_SHIFT_IR;
            JTG_UPDATE_IR:  next_state = tms_s ? JTG_SEL_DR : JTG_IDLE;
        endcase
    end

    // Controller state advances on each test clock rising edge
    always_ff @(posedge i_clk) begin
        if (tap_rst) begin
            state <= JTG_RESET;
        end else if (tck_rise) begin
            state <= next_state;
        end
    end

    // Instruction shift and update; reset selects DEVICE_IDENTIFICATION_WORD
    always_ff @(posedge i_clk) begin
        if (tap_rst) begin
            ir_sh <= `JTG_IR_CAPTURE;
            ir    <= `JTG_INS_DEVICE_IDENTIFICATION_WORD;
        end else if (tck_rise) begin
            unique case (state)
                JTG_RESET:      ir    <= `JTG_INS_DEVICE_IDENTIFICATION_WORD;
                JTG_CAPTURE_IR: ir_sh <= `JTG_IR_CAPTURE;
                JTG_SHIFT_IR:   ir_sh <= {tdi_s, ir_sh[`JTG_IR_W-1:1]};
                JTG_UPDATE_IR:  ir    <= ir_sh;
                default:        ir    <= ir;
            endcase
        end
    end

    // 32-bit data path for identification and user code; one-bit bypass
    always_ff @(posedge i_clk) begin
        if (tap_rst) begin
            dr_sh <= '0;
            byp   <= 1'b0;
        end else if (tck_rise) begin
            if (state == JTG_CAPTURE_DR) begin
                byp <= 1'b0;
                unique case (ir)
                    `JTG_INS_DEVICE_IDENTIFICATION_WORD:   dr_sh <= id_word;
                    `JTG_INS_USERCODE: dr_sh <= user_word;
                    default:           dr_sh <= '0;
                endcase
            end else if (state == JTG_SHIFT_DR) begin
                dr_sh <= {tdi_s, dr_sh[`JTG_DR_W-1:1]};
                byp   <= tdi_s;
            end
        end
    end

    // Boundary cells: sample pins on capture, drive them in EXTEST
    always_ff @(posedge i_clk) begin
        if (tap_rst) begin
            bsr_sh    <= '0;
            o_pin_out <= '0;
        end else if (tck_rise) begin
            if (state == JTG_CAPTURE_DR) begin
                bsr_sh <= pin_s;
            end else if (state == JTG_SHIFT_DR) begin
                bsr_sh <= {tdi_s, bsr_sh[NUM_PINS-1:1]};
            end else if (state == JTG_UPDATE_DR &&
                         (ir == `JTG_INS_EXTEST || ir == `JTG_INS_SAMPLE)) begin
                o_pin_out <= bsr_sh;
            end
        end
    end

    // Pins are handed to the scan cells only while EXTEST is current
    always_ff @(posedge i_clk) begin
        o_pin_extest <= !tap_rst && ir == `JTG_INS_EXTEST;
    end

    // Chip-level port follows the link while selected, idles otherwise
    always_ff @(posedge i_clk) begin
        if (!tap_rst && ir == `JTG_INS_CHIPTAP) begin
            o_chip_tck <= tck_s;
            o_chip_tms <= tms_s;
            o_chip_tdi <= tdi_s;
        end else begin
            o_chip_tck <= 1'b0;
            o_chip_tms <= 1'b1;
            o_chip_tdi <= 1'b1;
        end
    end

    // Output changes on the falling edge so the host samples it stable
    always_ff @(posedge i_clk) begin
        if (tap_rst) begin
            o_tdo      <= 1'b0;
            o_tdo_oe_n <= 1'b1;
        end else if (tck_fall) begin
            if (state == JTG_SHIFT_IR) begin
                o_tdo      <= ir_sh[0];
                o_tdo_oe_n <= 1'b0;
            end else if (state == JTG_SHIFT_DR) begin
                o_tdo_oe_n <= 1'b0;
                unique case (ir)
                    `JTG_INS_DEVICE_IDENTIFICATION_WORD,
                    `JTG_INS_USERCODE: o_tdo <= dr_sh[0];
                    `JTG_INS_EXTEST,
                    `JTG_INS_SAMPLE:   o_tdo <= bsr_sh[0];
                    `JTG_INS_CHIPTAP:  o_tdo <= ctdo_s;
                    default:           o_tdo <= byp;
                endcase
            end else begin
                o_tdo_oe_n <= 1'b1;
            end
        end
    end

    // Chip reset: asserts at once, releases on a clock edge
    always_ff @(posedge i_clk or negedge i_chip_rst_n) begin
        if (!i_chip_rst_n) begin
            crst_sync <= 2'b00;
        end else begin
            crst_sync <= {crst_sync[0], 1'b1};
        end
    end

    // Boot sequencer: wait for lock, then start in the strapped mode
    always_ff @(posedge i_clk or negedge i_chip_rst_n) begin
        if (!i_chip_rst_n) begin
            boot_state   <= JTG_BOOT_HELD;
            o_core_rst_n <= 1'b0;
            o_boot_start <= 1'b0;
        end else begin
            o_core_rst_n <= crst_sync[1];
            unique case (boot_state)
                JTG_BOOT_HELD: if (crst_sync[1]) begin
                    boot_state <= JTG_BOOT_LOCK;
                end
                JTG_BOOT_LOCK: if (lock_s) begin
                    boot_state   <= JTG_BOOT_RUN;
                    o_boot_start <= 1'b1;
                end
                JTG_BOOT_RUN: o_boot_start <= 1'b1;
                default: boot_state <= JTG_BOOT_HELD;
            endcase
        end
    end

    // Straps are caught at the moment boot begins, not under reset
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_boot_mode <= 2'h0;
        end else if (boot_state == JTG_BOOT_LOCK && lock_s) begin
            o_boot_mode <= cfg_s;
        end
    end

    // Deadline watch: flags a lock that arrives too late to boot in time
    always_ff @(posedge i_clk or negedge i_chip_rst_n) begin
        if (!i_chip_rst_n) begin
            init_cnt       <= '0;
            o_init_overrun <= 1'b0;
        end else if (boot_state == JTG_BOOT_LOCK) begin
            if (init_cnt == INIT_CYCLES - 1'b1) begin
                o_init_overrun <= 1'b1;
            end else begin
                init_cnt <= init_cnt + 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

//--- jtg_regs.svh
`ifndef JTG_REGS_SVH
`define JTG_REGS_SVH

// Scan path widths
`define JTG_IR_W          4
`define JTG_DR_W          32

// Instruction codes
`define JTG_INS_EXTEST    4'h0
`define JTG_INS_SAMPLE    4'h1
`define JTG_INS_DEVICE_IDENTIFICATION_WORD    4'h2
`define JTG_INS_USERCODE  4'h3
`define JTG_INS_CHIPTAP   4'h4
`define JTG_INS_BYPASS    4'hF

// Capture value of the instruction register (bits 1:0 are 01)
`define JTG_IR_CAPTURE    4'h1

// Identification word fields
`define JTG_ID_VER_MSB    31
`define JTG_ID_VER_LSB    28
`define JTG_ID_PART_MSB   27
`define JTG_ID_PART_LSB   12
`define JTG_ID_MFR_MSB    11
`define JTG_ID_MFR_LSB    1

// User code fields
`define JTG_UC_UID_MSB    31
`define JTG_UC_UID_LSB    22
`define JTG_UC_REV_MSB    15
`define JTG_UC_REV_LSB    0

// Security word fields
`define JTG_SEC_DIS_BIT   0
`define JTG_SEC_UID_MSB   31
`define JTG_SEC_UID_LSB   22

// Timing
`define JTG_CLK_PERIOD_NS 40
`define JTG_INIT_MAX_NS   150000
`define JTG_INIT_CYCLES   (`JTG_INIT_MAX_NS / `JTG_CLK_PERIOD_NS)
`define JTG_INIT_CNT_W    12

`endif

//--- jtg_pkg.sv
package jtg_pkg;

    // Test port controller states
    typedef enum logic [3:0] {
        JTG_RESET      = 4'h0,
        JTG_IDLE       = 4'h1,
        JTG_SEL_DR     = 4'h3,
        JTG_CAPTURE_DR = 4'h2,
        JTG_SHIFT_DR   = 4'h6,
        JTG_EXIT1_DR   = 4'h7,
        JTG_PAUSE_DR   = 4'h5,
        JTG_EXIT2_DR   = 4'h4,
        JTG_UPDATE_DR  = 4'hC,
        JTG_SEL_IR     = 4'hD,
        JTG_CAPTURE_IR = 4'hF,
        JTG_SHIFT_IR   = 4'hE,
        JTG_EXIT1_IR   = 4'hA,
        JTG_PAUSE_IR   = 4'hB,
        JTG_EXIT2_IR   = 4'h9,
        JTG_UPDATE_IR  = 4'h8
    } jtg_tap_state_type;

    // Boot sequencer states
    typedef enum logic [1:0] {
        JTG_BOOT_HELD = 2'h0,
        JTG_BOOT_LOCK = 2'h1,
        JTG_BOOT_RUN  = 2'h3
    } jtg_boot_state_type;

endpackage

//--- jtg_sync.sv
`timescale 1ns/10ps
`default_nettype none

// Two-flop synchroniser, one chain per bit
module jtg_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_sys_rst,
    // Data
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta;

    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
            // First stage feeds only the second stage
            always_ff @(posedge i_clk) begin
                if (i_sys_rst) begin
                    meta[g]   <= 1'b0;
                    o_sync[g] <= 1'b0;
                end else begin
                    meta[g]   <= i_async[g];
                    o_sync[g] <= meta[g];
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

//--- jtg_tap_chk.sv
`timescale 1ns/10ps
`default_nettype none

// Port-level checks on the test port and boot sequencer
module jtg_tap_chk #(
    parameter int NUM_PINS = 8
) (
    // Clock and resets
    input  wire logic                i_clk,
    input  wire logic                i_sys_rst,
    input  wire logic                i_trst_n,
    input  wire logic                i_chip_rst_n,
    // Watched inputs
    input  wire logic                i_pll_lock,
    input  wire logic [31:0]         i_otp_security,
    // Watched outputs
    input  wire logic                o_tdo_oe_n,
    input  wire logic                o_chip_tck,
    input  wire logic [NUM_PINS-1:0] o_pin_out,
    input  wire logic                o_pin_extest,
    input  wire logic                o_core_rst_n,
    input  wire logic                o_boot_start,
    input  wire logic [1:0]          o_boot_mode,
    input  wire logic                o_init_overrun
);
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);

    chip_rst_hold_a: assert property (
        !i_chip_rst_n |-> !o_boot_start && !o_core_rst_n)
        else $error("boot outputs active in chip reset");
    core_release_a: assert property (
        $rose(i_chip_rst_n) |-> !o_core_rst_n ##[2:3] o_core_rst_n)
        else $error("core reset release late");
    boot_lock_a: assert property (
        $rose(o_boot_start) |-> $past(i_pll_lock, 2))
        else $error("boot began without lock");
    boot_stays_a: assert property (
        o_boot_start |=> o_boot_start || !i_chip_rst_n)
        else $error("boot flag dropped");
    mode_hold_a: assert property (
        o_boot_start && $past(o_boot_start) |-> $stable(o_boot_mode))
        else $error("boot mode moved");
    trst_hold_a: assert property (
        !i_trst_n [*6] |-> o_tdo_oe_n && !o_pin_extest)
        else $error("port active in test reset");
    secure_lock_a: assert property (
        i_otp_security[0] [*6] |-> o_tdo_oe_n && !o_chip_tck)
        else $error("port active while disabled");
    init_overrun_a: assert property (
        $rose(o_init_overrun) |-> !o_boot_start)
        else $error("overrun after boot");
    sys_rst_a: assert property (disable iff (1'b0)
        i_sys_rst [*2] |=> o_tdo_oe_n && o_pin_out == '0 && !o_chip_tck)
        else $error("port not idle after reset");

    // Main scenarios reached
    cover property ($rose(o_boot_start));
    cover property ($fell(o_tdo_oe_n));
    cover property ($rose(o_pin_extest));
    cover property ($rose(o_init_overrun));
endmodule

bind jtg_tap jtg_tap_chk #(.NUM_PINS(NUM_PINS)) u_chk (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_trst_n(i_trst_n),
    .i_chip_rst_n(i_chip_rst_n), .i_pll_lock(i_pll_lock),
    .i_otp_security(i_otp_security), .o_tdo_oe_n(o_tdo_oe_n),
    .o_chip_tck(o_chip_tck), .o_pin_out(o_pin_out),
    .o_pin_extest(o_pin_extest), .o_core_rst_n(o_core_rst_n),
    .o_boot_start(o_boot_start), .o_boot_mode(o_boot_mode),
    .o_init_overrun(o_init_overrun));

`default_nettype wire

//--- jtg_host.sv
`timescale 1ns/10ps
`default_nettype none

// Test link host: tck rests low between frames, period 320 ns
module jtg_host (
    // Link pins
    output logic        o_tck,
    output logic        o_tms,
    output logic        o_tdi,
    input  wire logic   i_tdo,
    input  wire logic   i_tdo_oe_n,
    // Scan result strobe
    output logic [31:0] o_res,
    output logic        o_res_v
);
    logic [31:0] cap;

    // Idle link levels
    initial begin
        o_tck = 1'b0;
        o_tms = 1'b1;
        o_tdi = 1'b1;
        o_res_v = 1'b0;
    end

    // One tck period; tdo is taken just before the rise
    task step(input logic tms, input logic tdi);
        o_tms = tms;
        o_tdi = tdi;
        #160;
        cap = {i_tdo_oe_n ? 1'b1 : i_tdo, cap[31:1]};  // Released line pulled up
        o_tck = 1'b1;
        #160;
        o_tck = 1'b0;
    endtask

    // Walk n tms bits, lsb first, tdi high
    task walk(input logic [7:0] seq, input int n);
        for (int i = 0; i < n; i++) begin
            step(seq[i], 1'b1);
        end
    endtask

    // From idle: shift n bits lsb first, back to idle, strobe result
    task scan(input logic ir, input logic [31:0] din, input int n);
        walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i]);
        end
        o_res = cap >> (32 - n);
        walk(8'h01, 2);
        o_res_v = 1'b1;
        #40;
        o_res_v = 1'b0;
    endtask
endmodule

`default_nettype wire

//--- jtg_tap_and_reset_control_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module jtg_tap_and_reset_control_tb_top;
    // Identity fields: arbitrary values
    localparam logic [3:0]  VER   = 4'h3;
    localparam logic [15:0] PART  = 16'h5A5A;
    localparam logic [10:0] MAKER = 11'h2B7;
    localparam logic [15:0] REV   = 16'h00C4;
    localparam logic [31:0] ID    = {VER, PART, MAKER, 1'b1};

    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        trst_n = 1'b0;
    logic        chip_rst_n = 1'b0;
    logic        lock = 1'b0;
    logic        chip_tdo = 1'b0;
    logic [1:0]  cfg = 2'h0;
    logic [7:0]  pin_in = 8'h00;
    logic [31:0] sec = 32'h0;
    logic        tck, tms, tdi, tdo, tdo_oe_n, res_v, extest;
    logic        c_tck, c_tms, c_tdi, core_rst_n, boot_start, overrun;
    logic [1:0]  mode;
    logic [7:0]  pin_out;
    logic [31:0] res, d;
    logic [31:0] q[$];
    int          checks = 0;
    int          bad_count = 0;

    // 25 MHz clock
    always #20 clk = ~clk;

    jtg_tap #(.NUM_PINS(8), .ID_VERSION(VER), .ID_PART(PART),
        .ID_MAKER(MAKER), .SILICON_REV(REV)) DUT (
        .i_clk(clk), .i_sys_rst(sys_rst), .i_tck(tck), .i_tms(tms),
        .i_tdi(tdi), .i_trst_n(trst_n), .o_tdo(tdo), .o_tdo_oe_n(tdo_oe_n),
        .o_chip_tck(c_tck), .o_chip_tms(c_tms), .o_chip_tdi(c_tdi),
        .i_chip_tdo(chip_tdo), .i_pin_in(pin_in), .o_pin_out(pin_out),
        .o_pin_extest(extest), .i_otp_security(sec),
        .i_chip_rst_n(chip_rst_n), .i_pll_lock(lock), .i_boot_cfg(cfg),
        .o_core_rst_n(core_rst_n), .o_boot_start(boot_start),
        .o_boot_mode(mode), .o_init_overrun(overrun));

    jtg_host host (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(tdo),
        .i_tdo_oe_n(tdo_oe_n), .o_res(res), .o_res_v(res_v));

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task results;
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Load an instruction, then scan n bits of d; both results noted
    task ir_dr(input logic [3:0] code, input int n, input logic [31:0] e);
        q.push_back(32'h1);
        host.scan(1'b1, 32'(code), 4);
        q.push_back(e);
        host.scan(1'b0, d, n);
    endtask

    // Bounded wait for the boot flag
    task wait_boot;
        for (int n = 0; n < 20 && boot_start !== 1'b1; n++) begin
            @(negedge clk);
        end
    endtask

    // Scoreboard: each host result meets the oldest note
    always @(posedge clk) begin
        if (res_v === 1'b1) begin
            chk(res, q.size() > 0 ? q.pop_front() : 32'hX);
        end
    end

    // Main sequence
    initial begin
        void'($urandom(32'hD84C));
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        @(negedge clk);
        trst_n = 1'b1;
        cfg = 2'($urandom);
        chip_rst_n = 1'b1;
        repeat (20) @(negedge clk);
        chk(32'(boot_start), 32'h0);
        chk(32'(core_rst_n), 32'h1);
        lock = 1'b1;
        wait_boot();
        chk(32'(boot_start), 32'h1);
        chk(32'(mode), 32'(cfg));
        $display("test boot done");
        // Identity after reset and by instruction, user code, bypass
        host.walk(8'h00, 1);
        q.push_back(ID);
        host.scan(1'b0, 32'h0, 32);
        ir_dr(4'h2, 32, ID);
        for (int k = 0; k < 2; k++) begin
            sec = k ? 32'h0 : ($urandom & 32'hFFFFFFFE);
            ir_dr(4'h3, 32, {sec[31:22], 6'h0, REV});
        end
        for (int k = 0; k < 2; k++) begin
            d = $urandom;
            ir_dr(k ? 4'h7 : 4'hF, 32, {d[30:0], 1'b0});
        end
        $display("test scan done");
        // Boundary capture and update, then drive mode
        pin_in = 8'($urandom);
        d = $urandom;
        for (int k = 0; k < 2; k++) begin
            ir_dr(k ? 4'h0 : 4'h1, 8, 32'(pin_in));
            chk(32'(pin_out), 32'(d[7:0]));
            chk(32'(extest), 32'(k));
            d = ~d;
        end
        $display("test boundary done");
        // Chip-level port follows the link while selected
        q.push_back(32'h1);
        host.scan(1'b1, 32'h4, 4);
        for (int b = 0; b < 2; b++) begin
            host.step(1'b0, b[0]);
            chk(32'(c_tdi), 32'(b));
            chk(32'(c_tms), 32'h0);
            chk(32'(c_tck), 32'h1);
        end
        // Data from the chip-level port comes back on the top port
        chip_tdo = 1'b1;
        q.push_back(32'hFF);
        host.scan(1'b0, 32'h0, 8);
        host.walk(8'h1F, 6);
        q.push_back(ID);
        host.scan(1'b0, 32'h0, 32);
        $display("test chip port done");
        // Held test reset, then the disable bit, lock the port out
        for (int k = 0; k < 2; k++) begin
            if (k) begin
                sec[0] = 1'b1;
            end else begin
                trst_n = 1'b0;
            end
            repeat (4) @(negedge clk);
            host.walk(8'h03, 5);
            chk(32'(tdo_oe_n), 32'h1);
            trst_n = 1'b1;
            sec[0] = 1'b0;
            host.walk(8'h1F, 6);
        end
        $display("test lockout done");
        // Asynchronous chip reset, then a lock that comes late
        chip_rst_n = 1'b0;
        lock = 1'b0;
        #1;
        chk(32'(boot_start), 32'h0);
        chk(32'(core_rst_n), 32'h0);
        @(negedge clk);
        chip_rst_n = 1'b1;
        repeat (3800) @(negedge clk);
        chk(32'(overrun), 32'h1);
        lock = 1'b1;
        wait_boot();
        chk(32'(boot_start), 32'h1);
        $display("test reset done");
        results();
    end

    // Work needs about 7100 cycles; allow about eight times that
    initial begin
        #2400000;
        bad_count++;
        results();
    end
endmodule

`default_nettype wire
